/* hw/line_status_defs.vh */
// constants for the t1 line status register bank
// Functional notes
// R1 - The received message register shows the low eight bits of the ESF bit-oriented message codeword.
// R2 - That register loads a new codeword only after it has been seen in at least 8 of the last ten codeword positions; the code counts the last eleven.
// R3 - The loss-of-signal bit goes high when the line level stays over 40 dB below nominal for at least 1 ms, and is low otherwise.
// R4 - The transmit slip bit inverts on every controlled transmit frame slip.
// R5 - The slip direction bit reads one for a repeated frame (transmit clock fast) and zero for a lost frame.
// R6 - The slip direction bit changes only on a transmit slip.
// R7 - The buffer-depth msb reads one when the transmit buffer delay exceeds one frame, else zero; a 17H write holds it zero in the code until a depth change.
// R8 - The buffer-depth msb is cleared whenever the host writes the transmit slip buffer delay location 17H.
// R9 - The transmit timeslot field holds a five-bit timeslot offset refreshed every 250 us.
// R10 - The transmit bit count field holds a three-bit bit-time offset refreshed every 250 us.
// R11 - The two peak registers present the 8-bit converter readings of the receive line pair.
// R12 - The identification register returns a fixed eight-bit code on every read.
// R13 - Reads change no state, and writes to pure status locations are ignored.
`ifndef LINE_STATUS_DEFS_VH
`define LINE_STATUS_DEFS_VH
`define IDX_RX_MSG 6'h14
`define IDX_RX_SIG 6'h16
`define IDX_TX_SLIP 6'h17
`define IDX_TX_DELAY 6'h18
`define IDX_RAW_PEAK 6'h1D
`define IDX_EQ_PEAK 6'h1E
`define IDX_ID 6'h1F
`define IDX_IRQ_STAT 6'h20
`define IDX_IRQ_EN 6'h21
`define IDX_IRQ_CLR 6'h22
`define BIT_LOS 7
`define BIT_SLIP 7
`define BIT_SLIPDIR 6
`define BIT_DEPTH 5
`define DEVICE_CODE 8'h5A
`define LOS_TIME_US 1000
`define CLK_MHZ 40
`define LOS_CYCLES (`LOS_TIME_US * `CLK_MHZ)
`define REFRESH_TIME_US 250
`define REFRESH_CYCLES (`REFRESH_TIME_US * `CLK_MHZ)
`define MSG_MATCH_MIN 4'd8
`define MSG_WINDOW 10
`define IRQ_BITS 4
`endif

/* hw/t1_line_status_registers.v */
// t1 line status register bank with avalon-mm slave and interrupt
`timescale 1ns/1ps
`include "line_status_defs.vh"
module t1_line_status_registers #(
    parameter LOS_CYCLES = `LOS_CYCLES,
    parameter REFRESH_CYCLES = `REFRESH_CYCLES
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // avalon-mm slave, word index address
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // receive side status inputs (pins)
    input wire line_low_i,
    input wire [7:0] raw_peak_value_i,
    input wire [7:0] equalized_peak_value_i,
    // bit-oriented message codeword from the framer, same clock
    input wire [7:0] bom_codeword_i,
    input wire bom_codeword_valid_i,
    // transmit elastic buffer events, same clock
    input wire tx_slip_i,
    input wire tx_slip_repeat_i,
    input wire tx_depth_over_frame_i,
    input wire [4:0] tx_timeslot_offset_i,
    input wire [2:0] tx_bit_offset_i,
    // interrupt
    output reg irq_o
);
    // three-stage synchronisers for pin inputs
    reg [2:0] los_sync_q;
    reg [7:0] raw_s1_q, raw_s2_q, raw_s3_q;
    reg [7:0] eq_s1_q, eq_s2_q, eq_s3_q;
    reg [7:0] raw_peak_value_q, equalized_peak_value_q;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            los_sync_q <= 3'h0;
            raw_s1_q <= 8'h00;
            raw_s2_q <= 8'h00;
            raw_s3_q <= 8'h00;
            eq_s1_q <= 8'h00;
            eq_s2_q <= 8'h00;
            eq_s3_q <= 8'h00;
            raw_peak_value_q <= 8'h00;
            equalized_peak_value_q <= 8'h00;
        end else begin
            los_sync_q <= {los_sync_q[1:0], line_low_i};
            raw_s1_q <= raw_peak_value_i;
            raw_s2_q <= raw_s1_q;
            raw_s3_q <= raw_s2_q;
            eq_s1_q <= equalized_peak_value_i;
            eq_s2_q <= eq_s1_q;
            eq_s3_q <= eq_s2_q;
            // multi-bit converter words accepted only when stable
            if (raw_s2_q == raw_s3_q)
                raw_peak_value_q <= raw_s3_q; // [R11]
            if (eq_s2_q == eq_s3_q)
                equalized_peak_value_q <= eq_s3_q; // [R11]
        end
    end

    // loss-of-signal qualifier
    reg los_level_q;
    reg [31:0] los_cnt_q;
    reg line_signal_lost_q;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            los_level_q <= 1'b0;
            los_cnt_q <= 32'h0;
            line_signal_lost_q <= 1'b0;
        end else begin
            if (los_sync_q[1] == los_sync_q[2])
                los_level_q <= los_sync_q[2];
            if (!los_level_q) begin
                los_cnt_q <= 32'h0;
                line_signal_lost_q <= 1'b0; // [R3]
            end else if (los_cnt_q >= LOS_CYCLES - 1) begin
                line_signal_lost_q <= 1'b1; // [R3]
            end else begin
                los_cnt_q <= los_cnt_q + 32'h1;
            end
        end
    end

    // codeword history: last ten positions
    reg [7:0] hist_q [0:`MSG_WINDOW-1];
    reg [`MSG_WINDOW-1:0] hist_v_q;
    reg [7:0] rx_msg_q;
    reg [3:0] match_cnt;
    integer k;
    always @* begin
        match_cnt = 4'h0;
        for (k = 0; k < `MSG_WINDOW; k = k + 1)
            if (hist_v_q[k] && hist_q[k] == bom_codeword_i)
                match_cnt = match_cnt + 4'h1;
    end
    genvar g;
    generate
        for (g = 0; g < `MSG_WINDOW; g = g + 1) begin : g_hist
            // one process per entry keeps each history word single-driven
            always @(posedge clk_sys_i) begin
                if (rst_i)
                    hist_q[g] <= 8'h00;
                else if (bom_codeword_valid_i)
                    hist_q[g] <= (g == 0) ? bom_codeword_i : hist_q[(g == 0) ? 0 : g - 1];
            end
        end
    endgenerate
    reg msg_event_q;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            hist_v_q <= {`MSG_WINDOW{1'b0}};
            rx_msg_q <= 8'h00;
            msg_event_q <= 1'b0;
        end else begin
            msg_event_q <= 1'b0;
            if (bom_codeword_valid_i) begin
                hist_v_q <= {hist_v_q[`MSG_WINDOW-2:0], 1'b1};
                // current word counts with up to ten earlier ones
                if (match_cnt + 4'h1 >= `MSG_MATCH_MIN && rx_msg_q != bom_codeword_i) begin
                    rx_msg_q <= bom_codeword_i; // [R1] [R2]
                    msg_event_q <= 1'b1;
                end
            end
        end
    end

    // transmit slip state
    wire wr_hit = avs_write_i && avs_waitrequest_o == 1'b0;
    reg tx_slip_toggle_q, tx_slip_direction_q, tx_buffer_depth_msb_q;
    reg depth_prev_q;
    reg [4:0] tx_timeslot_offset_q;
    reg [2:0] tx_bit_offset_q;
    reg [31:0] refresh_cnt_q;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            tx_slip_toggle_q <= 1'b0;
            tx_slip_direction_q <= 1'b0;
            tx_buffer_depth_msb_q <= 1'b0;
            depth_prev_q <= 1'b0;
            tx_timeslot_offset_q <= 5'h00;
            tx_bit_offset_q <= 3'h0;
            refresh_cnt_q <= 32'h0;
        end else begin
            if (tx_slip_i) begin
                tx_slip_toggle_q <= ~tx_slip_toggle_q; // [R4]
                tx_slip_direction_q <= tx_slip_repeat_i; // [R5] [R6]
            end
            // host write to 17H clears the msb until the buffer reports a new depth
            depth_prev_q <= tx_depth_over_frame_i;
            if (wr_hit && avs_address_i == `IDX_TX_SLIP)
                tx_buffer_depth_msb_q <= 1'b0; // [R8]
            else if (tx_depth_over_frame_i != depth_prev_q)
                tx_buffer_depth_msb_q <= tx_depth_over_frame_i; // [R7]
            if (refresh_cnt_q >= REFRESH_CYCLES - 1) begin
                refresh_cnt_q <= 32'h0;
                tx_timeslot_offset_q <= tx_timeslot_offset_i; // [R9]
                tx_bit_offset_q <= tx_bit_offset_i; // [R10]
            end else begin
                refresh_cnt_q <= refresh_cnt_q + 32'h1;
            end
        end
    end

    // interrupt: 0 los rise, 1 slip, 2 new message, 3 los fall
    reg los_prev_q;
    reg [`IRQ_BITS-1:0] irq_stat_q, irq_en_q;
    wire [`IRQ_BITS-1:0] irq_evt = {los_prev_q & ~line_signal_lost_q, msg_event_q,
        tx_slip_i, line_signal_lost_q & ~los_prev_q};
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            los_prev_q <= 1'b0;
            irq_stat_q <= {`IRQ_BITS{1'b0}};
            irq_en_q <= {`IRQ_BITS{1'b0}};
            irq_o <= 1'b0;
        end else begin
            los_prev_q <= line_signal_lost_q;
            // set beats clear in the same cycle
            if (wr_hit && avs_address_i == `IDX_IRQ_CLR)
                irq_stat_q <= (irq_stat_q & ~avs_writedata_i[`IRQ_BITS-1:0]) | irq_evt;
            else
                irq_stat_q <= irq_stat_q | irq_evt;
            if (wr_hit && avs_address_i == `IDX_IRQ_EN)
                irq_en_q <= avs_writedata_i[`IRQ_BITS-1:0];
            irq_o <= |(irq_stat_q & irq_en_q);
        end
    end

    // bus slave: one wait cycle, then answer; reads have no side effects
    reg [7:0] rd_mux;
    always @* begin
        case (avs_address_i)
            `IDX_RX_MSG: rd_mux = rx_msg_q;
            `IDX_RX_SIG: rd_mux = {line_signal_lost_q, 7'h00};
            `IDX_TX_SLIP: rd_mux = {tx_slip_toggle_q, tx_slip_direction_q,
                tx_buffer_depth_msb_q, 5'h00};
            `IDX_TX_DELAY: rd_mux = {tx_timeslot_offset_q, tx_bit_offset_q};
            `IDX_RAW_PEAK: rd_mux = raw_peak_value_q;
            `IDX_EQ_PEAK: rd_mux = equalized_peak_value_q;
            `IDX_ID: rd_mux = `DEVICE_CODE; // [R12]
            `IDX_IRQ_STAT: rd_mux = {4'h0, irq_stat_q};
            `IDX_IRQ_EN: rd_mux = {4'h0, irq_en_q};
            default: rd_mux = 8'h00; // [R13]
        endcase
    end
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o)
                avs_readdata_o <= {24'h0, rd_mux};
        end
    end
endmodule // t1_line_status_registers

/* tb/line_status_checker_assertions.sv */
// port assertions for the t1 line status register bank
`timescale 1ns/1ps
`include "line_status_defs.vh"
module line_status_checker (
    // clock, reset and bus
    input wire clk_sys_i, input wire rst_i, input wire [5:0] avs_address_i,
    input wire avs_read_i, input wire avs_write_i, input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o, input wire avs_waitrequest_o, input wire irq_o,
    // status inputs
    input wire line_low_i, input wire [7:0] raw_peak_value_i,
    input wire [7:0] equalized_peak_value_i, input wire [7:0] bom_codeword_i,
    input wire bom_codeword_valid_i, input wire tx_slip_i, input wire tx_slip_repeat_i,
    input wire tx_depth_over_frame_i, input wire [4:0] tx_timeslot_offset_i,
    input wire [2:0] tx_bit_offset_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire rq = avs_read_i && avs_waitrequest_o;
    wire [5:0] a = avs_address_i;
    wire [31:0] q = avs_readdata_o;
    bus_answer_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    reset_idle_a: assert property ($past(rst_i) |-> avs_waitrequest_o && !irq_o)
        else $error("not idle after reset");
    upper_zero_a: assert property (!avs_waitrequest_o |-> q[31:8] == 24'h000000)
        else $error("upper read bits set");
    id_value_a: assert property (rq && a == `IDX_ID |=> q[7:0] == `DEVICE_CODE)
        else $error("wrong device code");
    raw_peak_a: assert property (
        ($stable(raw_peak_value_i)[*8] ##0 (rq && a == `IDX_RAW_PEAK))
        |=> q[7:0] == $past(raw_peak_value_i)) else $error("raw peak mismatch");
    eq_peak_a: assert property (
        ($stable(equalized_peak_value_i)[*8] ##0 (rq && a == `IDX_EQ_PEAK))
        |=> q[7:0] == $past(equalized_peak_value_i)) else $error("eq peak mismatch");
    los_clear_a: assert property (
        (!line_low_i[*8] ##0 (rq && a == `IDX_RX_SIG)) |=> q[7:0] == 8'h00)
        else $error("loss of signal with line present");
endmodule // line_status_checker
bind t1_line_status_registers line_status_checker i_line_status_checker (.*);

/* tb/t1_line_status_registers_tb_top.sv */
// self-checking bench for the t1 line status register bank
`timescale 1ns/1ps
`include "line_status_defs.vh"
module t1_line_status_registers_tb_top;
    reg clk_sys_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    reg [5:0] avs_address_i = 6'h00;
    reg [31:0] avs_writedata_i = 32'h0, seed = 32'h7EE7, rd, exp;
    reg line_low_i = 1'b0, bom_codeword_valid_i = 1'b0, tx_slip_i = 1'b0;
    reg tx_slip_repeat_i = 1'b0, tx_depth_over_frame_i = 1'b0, dprev = 1'b0;
    reg [7:0] raw_peak_value_i = 8'h00, equalized_peak_value_i = 8'h00, bom_codeword_i = 8'h00;
    reg [4:0] tx_timeslot_offset_i = 5'h00;
    reg [2:0] tx_bit_offset_i = 3'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, irq_o;
    integer n_fail = 0, n_compared = 0, cycles = 0, i;
    always #12.5 clk_sys_i = ~clk_sys_i;
    // short counts keep the run brief
    t1_line_status_registers #(.LOS_CYCLES(20), .REFRESH_CYCLES(8))
        i_t1_line_status_registers (.*);
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task tick(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task chk(input [31:0] got, input [31:0] want);
        begin
            n_compared = n_compared + 1;
            if (got !== want) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, got, want);
            end
        end
    endtask
    // sampled mid-cycle so the edge's own updates have landed
    task chk_irq(input want);
        begin
            @(negedge clk_sys_i);
            chk({31'h0, irq_o}, {31'h0, want});
            @(posedge clk_sys_i);
        end
    endtask
    task bus(input wr, input [5:0] a, input [31:0] wd);
        begin
            avs_address_i <= a;
            avs_writedata_i <= wd;
            avs_read_i <= !wr;
            avs_write_i <= wr;
            @(posedge clk_sys_i);
            while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
            rd = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
            @(posedge clk_sys_i);
        end
    endtask
    task rchk(input [5:0] a, input [31:0] want);
        begin
            bus(1'b0, a, 32'h0);
            chk(rd, want);
        end
    endtask
    task msg(input [7:0] w);
        begin
            bom_codeword_i <= w;
            bom_codeword_valid_i <= 1'b1;
            tick(1);
            bom_codeword_valid_i <= 1'b0;
            tick(1);
        end
    endtask
    task summarize;
        begin
            if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            summarize;
        end
    end
    initial begin
        tick(3);
        rst_i <= 1'b0;
        tick(1);
        bus(1'b1, `IDX_ID, 32'hFF);
        rchk(`IDX_ID, {24'h0, `DEVICE_CODE});
        rchk(6'h3F, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            {tx_bit_offset_i, tx_timeslot_offset_i} <= seed[23:16];
            {equalized_peak_value_i, raw_peak_value_i} <= seed[15:0];
            tick(20);
            rchk(`IDX_RAW_PEAK, {24'h0, seed[7:0]});
            rchk(`IDX_EQ_PEAK, {24'h0, seed[15:8]});
            rchk(`IDX_TX_DELAY, {24'h0, seed[20:16], seed[23:21]});
        end
        exp = 32'h0;
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            tx_depth_over_frame_i <= seed[0];
            tx_slip_repeat_i <= seed[1];
            tx_slip_i <= 1'b1;
            tick(1);
            tx_slip_i <= 1'b0;
            tx_slip_repeat_i <= ~seed[1];
            tick(3);
            exp = {24'h0, ~exp[7], seed[1], seed[0] & ~dprev, 5'h00};
            dprev = seed[0];
            rchk(`IDX_TX_SLIP, exp);
            bus(1'b1, `IDX_TX_SLIP, 32'hFF);
            rchk(`IDX_TX_SLIP, exp & 32'hDF);
        end
        bus(1'b1, `IDX_IRQ_CLR, 32'hF);
        line_low_i <= 1'b1;
        tick(10);
        rchk(`IDX_RX_SIG, 32'h0);
        tick(20);
        rchk(`IDX_RX_SIG, 32'h80);
        rchk(`IDX_IRQ_STAT, 32'h1);
        chk_irq(1'b0);
        bus(1'b1, `IDX_IRQ_EN, 32'h1);
        tick(2);
        chk_irq(1'b1);
        bus(1'b1, `IDX_IRQ_CLR, 32'h1);
        tick(2);
        chk_irq(1'b0);
        line_low_i <= 1'b0;
        tick(8);
        rchk(`IDX_RX_SIG, 32'h0);
        rchk(`IDX_IRQ_STAT, 32'h8);
        for (i = 0; i < 10; i = i + 1) msg(8'hC3);
        rchk(`IDX_RX_MSG, 32'hC3);
        // seven of ten is one short of the load threshold
        for (i = 0; i < 10; i = i + 1) msg((i % 4) ? 8'h3C : 8'h81);
        rchk(`IDX_RX_MSG, 32'hC3);
        msg(8'h3C);
        rchk(`IDX_RX_MSG, 32'h3C);
        summarize;
    end
endmodule // t1_line_status_registers_tb_top
